// ==== rtl/xoc_pkg.sv ====
// Package: register map, field layout and codes of the crystal oscillator
// Overview of operation
// - Oscillator enable field resets to disable code
// - Bits 23:12 code: 0xfab enables, 0xd1e disables
// - Any other on-code value enables oscillator
// - Band field reads 0xaa0, ignores writes
// - Startup timer counts crystal cycles, units 256
// - Timer expiry sets settled flag
// - Tick counter decrements per crystal cycle, stops
// - Pause code write stops oscillator, dormant
// - Dormant holds until wake interrupt or a non-dormant pause write
// - Wake restarts the crystal oscillator
// - After wake full startup delay applies
// - Pause register decodes dormant and wake codes
// - Status bit31 settled, bit24 illegal write
// - Settle count bits 13:0, bit20 quadruples
// - Tick counter 8 bits, reset zero
`default_nettype none
package xoc_pkg;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_PAUSE      = 8'h08;
  localparam logic [7:0]  ADDR_SETTLE     = 8'h0c;
  localparam logic [7:0]  ADDR_TICK       = 8'h1c;
  localparam int          ONCODE_LSB      = 12;
  localparam int          ONCODE_MSB      = 23;
  localparam logic [11:0] ONCODE_ENABLE   = 12'hfab;
  localparam logic [11:0] ONCODE_DISABLE  = 12'hd1e;
  localparam logic [11:0] BAND_RESET      = 12'haa0;
  localparam logic [11:0] BAND_RESERVED3  = 12'haa3;
  localparam logic [31:0] PAUSE_DORMANT   = 32'h636f6d61;
  localparam logic [31:0] PAUSE_WAKE      = 32'h77616b65;
  localparam int          STAT_SETTLED    = 31;
  localparam int          STAT_ILLEGAL    = 24;
  localparam int          STAT_ENABLED    = 12;
  localparam int          SETTLE_QUAD_BIT = 20;
  localparam int          SETTLE_W        = 14;
  localparam int          UNIT_SHIFT      = 8;
  localparam int          TICK_W          = 8;
  localparam int          TIMER_W         = SETTLE_W + UNIT_SHIFT + 2;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;

  // Latched AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } xoc_aphase_t;
endpackage : xoc_pkg
`default_nettype wire

// ==== rtl/xoc_timer.sv ====
// Startup timer: counts crystal cycles until settled
`timescale 1ns/10ps
`default_nettype none
module xoc_timer
  import xoc_pkg::*;
#(
  parameter int W = TIMER_W
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Control
  input  wire logic         run,
  input  wire logic         xtal_tick,
  input  wire logic [W-1:0] target,
  // Result
  output logic              settled
);
  logic [W-1:0] count;

  // Count crystal edges; stopping or pausing reloads from zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count   <= '0;
      settled <= 1'b0;
    end else if (!run) begin
      count   <= '0;
      settled <= 1'b0;
    end else if (!settled) begin
      if (count >= target) begin
        settled <= 1'b1;
      end else if (xtal_tick) begin
        count <= count + 1'b1;
      end
    end
  end

  // Settled never rises before the full count is seen
  property p_settle_needs_count;
    @(posedge hclk) disable iff (!hresetn)
      $rose(settled) |-> $past(count) >= $past(target);
  endproperty
  a_settle_needs_count: assert property (p_settle_needs_count)
    else $error("settled rose before the count elapsed");

  property p_stop_clears;
    @(posedge hclk) disable iff (!hresetn)
      !run |=> !settled;
  endproperty
  a_stop_clears: assert property (p_stop_clears)
    else $error("settled held while oscillator stopped");
endmodule : xoc_timer
`default_nettype wire

// ==== rtl/xoc_top.sv ====
// Crystal oscillator control block with AHB-Lite register slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module xoc_top
  import xoc_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Crystal side
  input  wire logic        crystal_in_pin,
  input  wire logic        wake_irq,
  output logic             osc_run,
  output logic             osc_settled
);
  xoc_aphase_t  aph;
  logic [11:0]  oncode;
  logic         dormant;
  logic         illegal_write_flag;
  logic [SETTLE_W-1:0] settle_count;
  logic         delay_quadruple;
  logic [TICK_W-1:0] tick_downcounter;
  logic         xtal_q;
  logic         xtal_tick;
  logic         wr_en;
  logic         enabled;
  logic         settled;
  logic         bad_oncode;
  logic         bad_band;
  logic         bad_pause;
  logic         clr_illegal;
  logic [TIMER_W-1:0] target;
  logic [31:0]  next_rdata;

  // On-code decode: every code except disable turns the oscillator on
  function automatic logic code_enables(input logic [11:0] code);
    return code != ONCODE_DISABLE;
  endfunction : code_enables

  // Slave never stalls and always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture; only NONSEQ/SEQ transfers count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph <= '0;
    end else if (hready) begin
      aph.valid <= hsel && (htrans == HTRANS_NONSEQ ||
                            htrans == HTRANS_SEQ);
      aph.write <= hwrite;
      aph.addr  <= haddr[7:0];
    end
  end

  assign wr_en = aph.valid && aph.write;

  // Crystal input is synchronous to hclk; a rising edge is one tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_q <= 1'b0;
    end else begin
      xtal_q <= crystal_in_pin;
    end
  end

  assign xtal_tick = crystal_in_pin && !xtal_q;

  // Write-data code checks for the illegal write flag
  always_comb begin
    bad_oncode = hwdata[ONCODE_MSB:ONCODE_LSB] != ONCODE_ENABLE &&
                 hwdata[ONCODE_MSB:ONCODE_LSB] != ONCODE_DISABLE;
    bad_band   = hwdata[11:0] < BAND_RESET ||
                 hwdata[11:0] > BAND_RESERVED3;
    bad_pause  = hwdata != PAUSE_DORMANT && hwdata != PAUSE_WAKE;
  end

  // Enable code register; resets to disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oncode <= ONCODE_DISABLE;
    end else if (wr_en && aph.addr == ADDR_CONTROL) begin
      oncode <= hwdata[ONCODE_MSB:ONCODE_LSB];
    end
  end

  assign enabled = code_enables(oncode);

  // Pause state: dormant code stops, wake interrupt restarts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dormant <= 1'b0;
    end else if (wake_irq) begin
      dormant <= 1'b0;
    end else if (wr_en && aph.addr == ADDR_PAUSE) begin
      dormant <= hwdata == PAUSE_DORMANT;
    end
  end

  // Settle count and quadruple bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_count    <= '0;
      delay_quadruple <= 1'b0;
    end else if (wr_en && aph.addr == ADDR_SETTLE) begin
      settle_count    <= hwdata[SETTLE_W-1:0];
      delay_quadruple <= hwdata[SETTLE_QUAD_BIT];
    end
  end

  // Illegal write flag; a new bad write beats a clearing write
  assign clr_illegal = wr_en && aph.addr == ADDR_STATUS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      illegal_write_flag <= 1'b0;
    end else if (wr_en && ((aph.addr == ADDR_CONTROL &&
                            (bad_oncode || bad_band)) ||
                           (aph.addr == ADDR_PAUSE && bad_pause))) begin
      illegal_write_flag <= 1'b1;
    end else if (clr_illegal) begin
      illegal_write_flag <= 1'b0;
    end
  end

  // Tick counter: written value, then one step per crystal edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_downcounter <= '0;
    end else if (wr_en && aph.addr == ADDR_TICK) begin
      tick_downcounter <= hwdata[TICK_W-1:0];
    end else if (osc_run && xtal_tick && tick_downcounter != '0) begin
      tick_downcounter <= tick_downcounter - 1'b1;
    end
  end

  // Oscillator runs when enabled and not paused
  assign osc_run = enabled && !dormant;

  // Target in crystal cycles: count times 256, times 4 if asked
  assign target = delay_quadruple ?
      {settle_count, {(UNIT_SHIFT + 2){1'b0}}} :
      {2'b00, settle_count, {UNIT_SHIFT{1'b0}}};

  // Timer restarts from zero on every wake, so full delay applies
  xoc_timer #(
    .W (TIMER_W)
  ) xoc_timer_inst (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .run       (osc_run),
    .xtal_tick (xtal_tick),
    .target    (target),
    .settled   (settled)
  );

  assign osc_settled = settled;

  // Read mux; band field always shows the fixed band code
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (aph.addr)
      ADDR_CONTROL: begin
        next_rdata[ONCODE_MSB:ONCODE_LSB] = oncode;
        next_rdata[11:0] = BAND_RESET;
      end
      ADDR_STATUS: begin
        next_rdata[STAT_SETTLED] = settled;
        next_rdata[STAT_ILLEGAL] = illegal_write_flag;
        next_rdata[STAT_ENABLED] = enabled;
      end
      ADDR_PAUSE: begin
        next_rdata = dormant ? PAUSE_DORMANT : PAUSE_WAKE;
      end
      ADDR_SETTLE: begin
        next_rdata[SETTLE_W-1:0]   = settle_count;
        next_rdata[SETTLE_QUAD_BIT] = delay_quadruple;
      end
      ADDR_TICK: begin
        next_rdata[TICK_W-1:0] = tick_downcounter;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data is combinational within the zero-wait data phase
  assign hrdata = (aph.valid && !aph.write) ? next_rdata : 32'h0000_0000;

  property p_reset_disabled;
    @(posedge hclk) disable iff (!hresetn)
      (oncode == ONCODE_DISABLE) |-> !osc_run;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled)
    else $error("oscillator runs with disable code");

  property p_enable_code;
    @(posedge hclk) disable iff (!hresetn)
      (wr_en && aph.addr == ADDR_CONTROL &&
       hwdata[ONCODE_MSB:ONCODE_LSB] == ONCODE_ENABLE) |=> enabled;
  endproperty
  a_enable_code: assert property (p_enable_code)
    else $error("enable code did not enable");

  property p_other_code;
    @(posedge hclk) disable iff (!hresetn)
      (wr_en && aph.addr == ADDR_CONTROL && bad_oncode) |=> enabled;
  endproperty
  a_other_code: assert property (p_other_code)
    else $error("undefined code did not enable");

  property p_band_fixed;
    @(posedge hclk) disable iff (!hresetn)
      (aph.valid && !aph.write && aph.addr == ADDR_CONTROL)
        |-> hrdata[11:0] == BAND_RESET;
  endproperty
  a_band_fixed: assert property (p_band_fixed)
    else $error("band field changed");

  property p_tick_step;
    @(posedge hclk) disable iff (!hresetn)
      (osc_run && xtal_tick && tick_downcounter != '0 &&
       !(wr_en && aph.addr == ADDR_TICK))
        |=> tick_downcounter == $past(tick_downcounter) - 8'h01;
  endproperty
  a_tick_step: assert property (p_tick_step)
    else $error("tick counter did not step");

  property p_tick_stop;
    @(posedge hclk) disable iff (!hresetn)
      (tick_downcounter == '0 && !(wr_en && aph.addr == ADDR_TICK))
        |=> tick_downcounter == '0;
  endproperty
  a_tick_stop: assert property (p_tick_stop)
    else $error("tick counter moved past zero");

  property p_dormant_stops;
    @(posedge hclk) disable iff (!hresetn)
      (wr_en && aph.addr == ADDR_PAUSE && hwdata == PAUSE_DORMANT &&
       !wake_irq) |=> !osc_run ##1 !osc_settled;
  endproperty
  a_dormant_stops: assert property (p_dormant_stops)
    else $error("pause code did not stop oscillator");

  property p_wake;
    @(posedge hclk) disable iff (!hresetn)
      (wake_irq && enabled && !(wr_en && aph.addr == ADDR_CONTROL))
        |=> osc_run;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not restart oscillator");

  property p_illegal_flag;
    @(posedge hclk) disable iff (!hresetn)
      (wr_en && aph.addr == ADDR_PAUSE && bad_pause)
        |=> illegal_write_flag;
  endproperty
  a_illegal_flag: assert property (p_illegal_flag)
    else $error("bad pause write not flagged");
endmodule : xoc_top
`default_nettype wire

// ==== verification/xoc_crystal_model.sv ====
// Crystal source model driving the crystal input pin
`timescale 1ns/10ps
`default_nettype none
module xoc_crystal_model (
  // Clock
  input  wire logic hclk,
  // Control from the block and the bench
  input  wire logic run,
  input  wire logic slow,
  // Crystal output
  output logic      crystal_in_pin
);
  logic [2:0] cnt;

  // Stopped crystal sits low; half period two or three hclk cycles
  always_ff @(posedge hclk) begin
    if (!run) begin
      cnt            <= 3'h0;
      crystal_in_pin <= 1'b0;
    end else if (cnt == (slow ? 3'h2 : 3'h1)) begin
      cnt            <= 3'h0;
      crystal_in_pin <= ~crystal_in_pin;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule : xoc_crystal_model
`default_nettype wire

// ==== verification/crystal_oscillator_control_bench.sv ====
// Self-checking bench for the crystal oscillator control block
`timescale 1ns/10ps
`default_nettype none
module crystal_oscillator_control_bench;
  import xoc_pkg::*;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} xoc_exp_t;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, seed, last_rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        crystal_in_pin, wake_irq, osc_run, osc_settled;
  logic        slow, rd_pend;
  logic [11:0] code;
  xoc_exp_t    expq[$];
  xoc_exp_t    e;
  int          n_fail, n_compared, cyc, i;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  xoc_top xoc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .crystal_in_pin(crystal_in_pin),
    .wake_irq(wake_irq), .osc_run(osc_run), .osc_settled(osc_settled));
  xoc_crystal_model xoc_crystal_model_inst (.hclk(hclk), .run(osc_run),
    .slow(slow), .crystal_in_pin(crystal_in_pin));

  always #5 hclk = ~hclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input bit ok);
    n_compared++;
    if (!ok) begin
      n_fail++;
      $display("wrong value at %0t: port check", $time);
    end
  endtask : check

  task automatic conclude;
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // One single transfer; read expectation noted at address acceptance
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    if (!w) expq.push_back('{d, m});
    hsel    <= 1'b0;
    htrans  <= 2'h0;
    hwdata  <= w ? d : 32'h0;
    rd_pend <= !w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd_pend <= 1'b0;
    last_rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m);
    xfer(1'b0, a, v, m);
  endtask : rd

  // Cycles until settled must match ticks times crystal period
  task automatic wait_settle(input int ticks, input int per);
    int n;
    n = 0;
    while (osc_settled !== 1'b1 && n < 8000) begin
      @(posedge hclk);
      n++;
    end
    check(n >= ticks * per - per && n <= ticks * per + per + 4);
  endtask : wait_settle

  // Read data checker: oldest note against the data phase result
  always @(posedge hclk) begin
    if (rd_pend === 1'b1 && hready === 1'b1) begin
      e = expq.pop_front();
      if (e.m != 32'h0) begin
        n_compared++;
        if ((hrdata & e.m) !== e.v) begin
          n_fail++;
          $display("wrong value at %0t: read data %h", $time, hrdata);
        end
      end
    end
  end

  // Hang guard, well above the longest settle wait
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    hclk     = 1'b0;
    hresetn  = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    wake_irq = 1'b0;
    slow     = 1'b0;
    rd_pend  = 1'b0;
    seed     = 32'hc321cd7d;
    cyc      = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset state
    rd(ADDR_CONTROL, {8'h0, ONCODE_DISABLE, BAND_RESET}, 32'h00ff_ffff);
    rd(ADDR_STATUS, 32'h0, 32'h8100_1000);
    rd(ADDR_PAUSE, PAUSE_WAKE, 32'hffff_ffff);
    rd(ADDR_SETTLE, 32'h0, 32'h0010_3fff);
    rd(ADDR_TICK, 32'h0, 32'h0000_00ff);
    check(osc_run === 1'b0);
    // Settle count rounded up from 200 ticks, then enable
    wr(ADDR_SETTLE, (200 + 255) / 256);
    wr(ADDR_CONTROL, {8'h0, ONCODE_ENABLE, BAND_RESET});
    wait_settle(256, 4);
    rd(ADDR_STATUS, 32'h8000_1000, 32'h8100_1000);
    // Tick counter runs down to zero and stops
    seed = lfsr(seed);
    wr(ADDR_TICK, {24'h0, seed[7:0] | 8'h80});
    i = 0;
    do begin
      rd(ADDR_TICK, 32'h0, 32'h0);
      i++;
    end while (last_rd[7:0] !== 8'h0 && i < 1000);
    check(last_rd[7:0] === 8'h0 && i > 8);
    rd(ADDR_TICK, 32'h0, 32'h0000_00ff);
    // Band field ignores writes, bad band flagged
    wr(ADDR_CONTROL, {8'h0, ONCODE_ENABLE, 12'h123});
    rd(ADDR_CONTROL, {8'h0, ONCODE_ENABLE, BAND_RESET}, 32'h00ff_ffff);
    rd(ADDR_STATUS, 32'h0100_0000, 32'h0100_0000);
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS, 32'h0, 32'h0100_0000);
    // Undefined on-codes still enable and raise the flag
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      code = seed[11:0];
      if (code == ONCODE_ENABLE || code == ONCODE_DISABLE) code = 12'h0;
      wr(ADDR_CONTROL, {8'h0, code, BAND_RESET});
      rd(ADDR_STATUS, 32'h0100_1000, 32'h0100_1000);
      check(osc_run === 1'b1);
      wr(ADDR_STATUS, 32'h0);
    end
    // Dormant, wake, and a full quadrupled delay at a slower crystal
    wr(ADDR_SETTLE, 32'h0010_0001);
    rd(ADDR_SETTLE, 32'h0010_0001, 32'h0010_3fff);
    wr(ADDR_PAUSE, PAUSE_DORMANT);
    rd(ADDR_PAUSE, PAUSE_DORMANT, 32'hffff_ffff);
    check(osc_run === 1'b0 && osc_settled === 1'b0);
    repeat (50) @(posedge hclk);
    check(osc_run === 1'b0);
    slow     <= 1'b1;
    wake_irq <= 1'b1;
    @(posedge hclk);
    wake_irq <= 1'b0;
    @(posedge hclk);
    check(osc_run === 1'b1);
    wait_settle(1024, 6);
    rd(ADDR_PAUSE, PAUSE_WAKE, 32'hffff_ffff);
    // Disable clears settled; bad pause write selects wake
    wr(ADDR_CONTROL, {8'h0, ONCODE_DISABLE, BAND_RESET});
    rd(ADDR_STATUS, 32'h0, 32'h8000_1000);
    check(osc_run === 1'b0);
    wr(ADDR_PAUSE, 32'h1234_5678);
    rd(ADDR_PAUSE, PAUSE_WAKE, 32'hffff_ffff);
    rd(ADDR_STATUS, 32'h0100_0000, 32'h0100_0000);
    rd(8'h10, 32'h0, 32'hffff_ffff);
    check(hresp === 1'b0 && hreadyout === 1'b1);
    conclude();
  end
endmodule : crystal_oscillator_control_bench
`default_nettype wire
